/* File: hw/rnhp_pkg.sv */
// Constants shared by both ends of the nibble host port
// How it works
// - 80 style: drive data on select and read
// - 68 style: drive data on select, read, enable
// - Otherwise data pins stay undriven
// - Data bits are active high both ways
// - Host picks the register by four-bit index
// - Access uses the latched index value
// - Latch strobe high: index and select follow
// - Latch strobe low: captured values are held
// - Power-sense select is never latched
// - Host without latch ties strobe high
// - Shared-address host may select through latch
// - Host maps strobes onto two shared inputs
// - Deselected: strobes forced to their idle levels
// - Style select is static: high means 68
package rnhp_pkg;
    localparam int DATA_W  = 4;
    localparam int INDEX_W = 4;
    localparam int REGS    = 16;
    localparam logic [DATA_W-1:0]  DATA_RST  = 4'h0;
    localparam logic [INDEX_W-1:0] INDEX_RST = 4'h0;
    // Host phase lengths in clk_sys cycles (5 ns period)
    localparam int CLK_NS     = 5;
    localparam int T_SETUP_NS = 100;
    localparam int T_PULSE_NS = 220;
    localparam int T_HOLD_NS  = 100;
    localparam int SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 8;
    typedef enum logic [1:0]
    {
        RNHP_IDLE  = 2'b00,
        RNHP_SETUP = 2'b01,
        RNHP_PULSE = 2'b11,
        RNHP_HOLD  = 2'b10
    } rnhp_state_t;
endpackage

/* File: hw/rnhp_if.sv */
// Pin bundle between the microcomputer and the nibble port
`timescale 1ns/1ps
`default_nettype none
interface rnhp_if;
    import rnhp_pkg::*;
    logic                 style_68;
    logic                 latch_strobe;
    logic                 primary_select_n;
    logic                 power_sense_select;
    logic                 wr_or_rnw;
    logic                 rd_or_en;
    logic [INDEX_W-1:0]   register_index;
    logic [DATA_W-1:0]    host_data_out;
    logic                 host_data_oe;
    logic [DATA_W-1:0]    dev_data_out;
    logic                 dev_data_oe;
    logic [DATA_W-1:0]    data_nibble;
    // Wire level resolved from the two enables; no driver floats as 0
    assign data_nibble = dev_data_oe ? dev_data_out :
                         (host_data_oe ? host_data_out : DATA_RST);
    modport device
    (
        input  style_68,
        input  latch_strobe,
        input  primary_select_n,
        input  power_sense_select,
        input  wr_or_rnw,
        input  rd_or_en,
        input  register_index,
        input  data_nibble,
        output dev_data_out,
        output dev_data_oe
    );
    modport host
    (
        output style_68,
        output latch_strobe,
        output primary_select_n,
        output power_sense_select,
        output wr_or_rnw,
        output rd_or_en,
        output register_index,
        output host_data_out,
        output host_data_oe,
        input  data_nibble
    );
endinterface
`default_nettype wire

/* File: hw/rnhp_device.sv */
// Device end: latch, qualification, register file and data drive
`timescale 1ns/1ps
`default_nettype none
module rnhp_device
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    rnhp_if.device                             bus,
    input  wire logic [rnhp_pkg::INDEX_W-1:0]  peek_index,
    output logic      [rnhp_pkg::DATA_W-1:0]   peek_data,
    output logic                               wr_done,
    output logic      [rnhp_pkg::INDEX_W-1:0]  latched_index
);
    import rnhp_pkg::*;

    logic                 sel_live;
    logic                 latch_q;
    logic [INDEX_W-1:0]   idx_ff;
    logic                 cs0_ff;
    logic [INDEX_W-1:0]   nxt_idx;
    logic                 nxt_cs0;
    logic                 qual;
    logic                 wr_act;
    logic                 rd_act;
    logic [1:0]           wsync_ff;
    logic [1:0]           nxt_wsync;
    logic [DATA_W-1:0]    dsamp_ff;
    logic [DATA_W-1:0]    nxt_dsamp;
    logic [INDEX_W-1:0]   isamp_ff;
    logic [INDEX_W-1:0]   nxt_isamp;
    logic                 wprev_ff;
    logic                 nxt_wprev;
    logic                 wr_done_ff;
    logic                 nxt_wr_done;
    logic [DATA_W-1:0]    regs_ff [REGS];
    logic [DATA_W-1:0]    rdata_ff;
    logic [DATA_W-1:0]    nxt_rdata;
    logic                 w_end;

    // Live power-sense select gates everything; never latched
    assign sel_live = bus.power_sense_select;
    assign latch_q  = bus.latch_strobe & sel_live;

    always_comb
    begin
        nxt_idx = idx_ff;
        nxt_cs0 = cs0_ff;
        if (latch_q)
        begin
            nxt_idx = bus.register_index;
            nxt_cs0 = bus.primary_select_n;
        end
    end

    // Transparent while strobe high: index used is mux of pin and held copy
    assign latched_index = latch_q ? bus.register_index : idx_ff;
    assign qual = ~(latch_q ? bus.primary_select_n : cs0_ff) & sel_live;

    always_comb
    begin
        if (bus.style_68)
        begin
            rd_act = qual & bus.wr_or_rnw & bus.rd_or_en;
            wr_act = qual & ~bus.wr_or_rnw & bus.rd_or_en;
        end
        else
        begin
            rd_act = qual & ~bus.rd_or_en & bus.wr_or_rnw;
            wr_act = qual & ~bus.wr_or_rnw & bus.rd_or_en;
        end
    end

    // Drive only when reading; undriven in every other case
    assign bus.dev_data_oe  = rd_act;
    assign bus.dev_data_out = rdata_ff;

    always_comb
    begin
        nxt_wsync   = {wsync_ff[0], wr_act};
        nxt_wprev   = wsync_ff[1];
        nxt_dsamp   = dsamp_ff;
        nxt_isamp   = isamp_ff;
        // Data and index captured while write is stably active
        if (wsync_ff[1])
        begin
            nxt_dsamp = bus.data_nibble;
            nxt_isamp = latched_index;
        end
        w_end       = wprev_ff & ~wsync_ff[1];
        nxt_wr_done = w_end;
        nxt_rdata   = regs_ff[latched_index];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            idx_ff     <= INDEX_RST;
            cs0_ff     <= 1'b1;
            wsync_ff   <= 2'b00;
            wprev_ff   <= 1'b0;
            dsamp_ff   <= DATA_RST;
            isamp_ff   <= INDEX_RST;
            wr_done_ff <= 1'b0;
            rdata_ff   <= DATA_RST;
        end
        else
        begin
            idx_ff     <= nxt_idx;
            cs0_ff     <= nxt_cs0;
            wsync_ff   <= nxt_wsync;
            wprev_ff   <= nxt_wprev;
            dsamp_ff   <= nxt_dsamp;
            isamp_ff   <= nxt_isamp;
            wr_done_ff <= nxt_wr_done;
            rdata_ff   <= nxt_rdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < REGS; g++)
        begin : g_reg
            logic [DATA_W-1:0] nxt_reg;
            always_comb
            begin
                nxt_reg = regs_ff[g];
                if (w_end && isamp_ff == INDEX_W'(g))
                begin
                    nxt_reg = dsamp_ff;
                end
            end
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    regs_ff[g] <= DATA_RST;
                end
                else
                begin
                    regs_ff[g] <= nxt_reg;
                end
            end
        end
    endgenerate

    assign peek_data = regs_ff[peek_index];
    assign wr_done   = wr_done_ff;
endmodule // rnhp_device
`default_nettype wire

/* File: hw/rnhp_host.sv */
// Host end: sequences one read or write over the pins
`timescale 1ns/1ps
`default_nettype none
module rnhp_host
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    rnhp_if.host                               bus,
    input  wire logic                          cfg_style_68,
    input  wire logic                          cfg_use_latch,
    input  wire logic                          req_valid,
    input  wire logic                          req_write,
    input  wire logic [rnhp_pkg::INDEX_W-1:0]  req_index,
    input  wire logic [rnhp_pkg::DATA_W-1:0]   req_wdata,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic      [rnhp_pkg::DATA_W-1:0]   rsp_rdata
);
    import rnhp_pkg::*;

    rnhp_state_t          st_ff;
    rnhp_state_t          nxt_st;
    logic [CNT_W-1:0]     cnt_ff;
    logic [CNT_W-1:0]     nxt_cnt;
    logic                 wr_ff;
    logic                 nxt_wr;
    logic [INDEX_W-1:0]   idx_ff;
    logic [INDEX_W-1:0]   nxt_idx;
    logic [DATA_W-1:0]    wd_ff;
    logic [DATA_W-1:0]    nxt_wd;
    logic                 rv_ff;
    logic                 nxt_rv;
    logic [DATA_W-1:0]    rd_ff;
    logic [DATA_W-1:0]    nxt_rd;
    logic                 strobe;

    assign req_ready = (st_ff == RNHP_IDLE);

    always_comb
    begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff - CNT_W'(1);
        nxt_wr  = wr_ff;
        nxt_idx = idx_ff;
        nxt_wd  = wd_ff;
        nxt_rv  = 1'b0;
        nxt_rd  = rd_ff;
        case (st_ff)
            RNHP_IDLE:
            begin
                nxt_cnt = CNT_W'(SETUP_CYC - 1);
                if (req_valid)
                begin
                    nxt_st  = RNHP_SETUP;
                    nxt_wr  = req_write;
                    nxt_idx = req_index;
                    nxt_wd  = req_wdata;
                end
            end
            RNHP_SETUP:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_st  = RNHP_PULSE;
                    nxt_cnt = CNT_W'(PULSE_CYC - 1);
                end
            end
            RNHP_PULSE:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_st  = RNHP_HOLD;
                    nxt_cnt = CNT_W'(HOLD_CYC - 1);
                    if (!wr_ff)
                    begin
                        nxt_rd = bus.data_nibble;
                        nxt_rv = 1'b1;
                    end
                end
            end
            RNHP_HOLD:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_st = RNHP_IDLE;
                end
            end
            default:
            begin
                nxt_st = RNHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_ff  <= RNHP_IDLE;
            cnt_ff <= '0;
            wr_ff  <= 1'b0;
            idx_ff <= INDEX_RST;
            wd_ff  <= DATA_RST;
            rv_ff  <= 1'b0;
            rd_ff  <= DATA_RST;
        end
        else
        begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            wr_ff  <= nxt_wr;
            idx_ff <= nxt_idx;
            wd_ff  <= nxt_wd;
            rv_ff  <= nxt_rv;
            rd_ff  <= nxt_rd;
        end
    end

    assign strobe = (st_ff == RNHP_PULSE);
    assign bus.style_68           = cfg_style_68;
    assign bus.power_sense_select = 1'b1;
    // Latch open only in setup when used; otherwise tied high
    assign bus.latch_strobe = cfg_use_latch ? (st_ff == RNHP_SETUP) : 1'b1;
    assign bus.primary_select_n = (st_ff == RNHP_IDLE);
    assign bus.register_index   = idx_ff;
    always_comb
    begin
        if (cfg_style_68)
        begin
            bus.wr_or_rnw = ~wr_ff | (st_ff == RNHP_IDLE);
            bus.rd_or_en  = strobe;
        end
        else
        begin
            bus.wr_or_rnw = ~(strobe & wr_ff);
            bus.rd_or_en  = ~(strobe & ~wr_ff);
        end
    end
    assign bus.host_data_oe  = wr_ff & (st_ff != RNHP_IDLE);
    assign bus.host_data_out = wd_ff;
    assign rsp_valid = rv_ff;
    assign rsp_rdata = rd_ff;
endmodule // rnhp_host
`default_nettype wire

/* File: tb/rnhp_chk.sv */
// Pin checker for the nibble host port
`timescale 1ns/1ps
`default_nettype none
module rnhp_chk
(
    input wire logic                         clk_sys,
    input wire logic                         rst,
    input wire logic                         style_68,
    input wire logic                         latch_strobe,
    input wire logic                         primary_select_n,
    input wire logic                         power_sense_select,
    input wire logic                         wr_or_rnw,
    input wire logic                         rd_or_en,
    input wire logic [rnhp_pkg::DATA_W-1:0]  dev_data_out,
    input wire logic                         dev_data_oe,
    input wire logic [rnhp_pkg::DATA_W-1:0]  data_nibble
);
    import rnhp_pkg::*;
    logic sel_n_ff;
    logic nxt_sel_n;
    logic sel_q;
    logic rd_q;
    logic act_q;
    // Transparent while strobe high, held otherwise
    always_comb
    begin
        nxt_sel_n = latch_strobe ? primary_select_n : sel_n_ff;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sel_n_ff <= 1'b1;
        end
        else
        begin
            sel_n_ff <= nxt_sel_n;
        end
    end
    assign sel_q = !nxt_sel_n && power_sense_select;
    assign rd_q = sel_q && wr_or_rnw && (style_68 ? rd_or_en : !rd_or_en);
    assign act_q = sel_q && (style_68 ? rd_or_en : !(rd_or_en && wr_or_rnw));
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_act_start;
        $rose(act_q);
    endsequence
    sequence s_act_hold;
        act_q [*8];
    endsequence
    property p_drive80; !style_68 && rd_q |-> dev_data_oe; endproperty
    property p_drive68; style_68 && rd_q |-> dev_data_oe; endproperty
    property p_float; !rd_q |-> !dev_data_oe; endproperty
    property p_wire; dev_data_oe |-> data_nibble == dev_data_out; endproperty
    property p_rd_stable; rd_q [*2] |-> $stable(dev_data_out); endproperty
    property p_both80; !style_68 |-> (wr_or_rnw || rd_or_en); endproperty
    property p_style; !primary_select_n |-> $stable(style_68); endproperty
    property p_pulse; s_act_start |-> s_act_hold; endproperty
    property p_deselect; primary_select_n && latch_strobe |-> !dev_data_oe; endproperty
    a_drive80: assert property (p_drive80) else $error("no drive on read");
    a_drive68: assert property (p_drive68) else $error("no drive on read");
    a_float: assert property (p_float) else $error("drive outside read");
    a_wire: assert property (p_wire) else $error("wire differs");
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
    a_both80: assert property (p_both80) else $error("both strobes low");
    a_style: assert property (p_style) else $error("style moved");
    a_pulse: assert property (p_pulse) else $error("strobe too short");
    a_deselect: assert property (p_deselect) else $error("drive deselected");
endmodule // rnhp_chk
`default_nettype wire

/* File: tb/rtc_nibble_host_port_test.sv */
// Testbench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module rtc_nibble_host_port_test;
    import rnhp_pkg::*;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               cfg_style_68 = 1'b0;
    logic               cfg_use_latch = 1'b0;
    logic               req_valid = 1'b0;
    logic               req_write = 1'b0;
    logic [INDEX_W-1:0] req_index = 4'h0;
    logic [DATA_W-1:0]  req_wdata = 4'h0;
    logic [INDEX_W-1:0] peek_index = 4'h0;
    logic               req_ready;
    logic               rsp_valid;
    logic [DATA_W-1:0]  rsp_rdata;
    logic [DATA_W-1:0]  peek_data;
    logic               wr_done;
    logic [INDEX_W-1:0] latched_index;
    int                 error_cnt = 0;
    int                 samples_checked = 0;
    rnhp_if bus ();
    always #2.5 clk_sys = ~clk_sys;
    rnhp_host rnhp_host_inst
    (
        .clk_sys(clk_sys), .rst(rst), .bus(bus), .cfg_style_68(cfg_style_68),
        .cfg_use_latch(cfg_use_latch), .req_valid(req_valid), .req_write(req_write),
        .req_index(req_index), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata)
    );
    rnhp_device rnhp_device_inst
    (
        .clk_sys(clk_sys), .rst(rst), .bus(bus), .peek_index(peek_index),
        .peek_data(peek_data), .wr_done(wr_done), .latched_index(latched_index)
    );
    rnhp_chk rnhp_chk_inst
    (
        .clk_sys(clk_sys), .rst(rst), .style_68(bus.style_68),
        .latch_strobe(bus.latch_strobe), .primary_select_n(bus.primary_select_n),
        .power_sense_select(bus.power_sense_select), .wr_or_rnw(bus.wr_or_rnw),
        .rd_or_en(bus.rd_or_en), .dev_data_out(bus.dev_data_out),
        .dev_data_oe(bus.dev_data_oe), .data_nibble(bus.data_nibble)
    );
    task automatic give_verdict();
        $display("mismatches %0d of %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait: 0 ready, 1 read answer, 2 write commit
    task automatic await(input int sel);
        logic [2:0] f;
        for (int n = 0; n < 200; n++)
        begin
            f = {wr_done, rsp_valid, req_ready};
            if (f[sel] === 1'b1)
                return;
            @(negedge clk_sys);
        end
        error_cnt++;
        give_verdict();
    endtask
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [3:0] wd);
        await(0);
        req_valid = 1'b1;
        req_write = wr;
        req_index = idx;
        req_wdata = wd;
        peek_index = idx;
        @(negedge clk_sys);
        req_valid = 1'b0;
        await(wr ? 2 : 1);
        // Hold phase must end before any setting changes under a live select
        await(0);
    endtask
    task automatic t_plain_80();
        for (int i = 0; i < REGS; i++)
        begin
            peek_index = 4'(i);
            @(negedge clk_sys);
            check("reset reg", peek_data, DATA_RST);
        end
        for (int i = 0; i < REGS; i++)
        begin
            xfer(1'b1, 4'(i), ~4'(i));
            check("stored", peek_data, ~4'(i));
        end
        for (int i = 0; i < REGS; i++)
        begin
            xfer(1'b0, 4'(i), 4'h0);
            check("read", rsp_rdata, ~4'(i));
        end
    endtask
    task automatic t_latched();
        cfg_use_latch = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            cfg_style_68 = s[0];
            xfer(1'b1, 4'hf, 4'(6 + s));
            check("latched", latched_index, 4'hf);
            xfer(1'b0, 4'hf, 4'h0);
            check("read", rsp_rdata, 4'(6 + s));
            xfer(1'b0, 4'h1, 4'h0);
            check("read", rsp_rdata, s[0] ? 4'h9 : 4'he);
            xfer(1'b1, 4'h1, 4'h9);
            check("index", latched_index, 4'h1);
            check("stored", peek_data, 4'h9);
        end
    endtask
    task automatic t_mid_reset();
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        peek_index = 4'h1;
        @(negedge clk_sys);
        check("after reset", peek_data, DATA_RST);
        xfer(1'b0, 4'h1, 4'h0);
        check("read", rsp_rdata, DATA_RST);
    endtask
    initial
    begin
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        t_plain_80();
        t_latched();
        t_mid_reset();
        give_verdict();
    end
endmodule // rtc_nibble_host_port_test
`default_nettype wire
